// ---- rtl/iar_alu_rotate.sv ----
// Immediate ALU and accumulator rotate unit with APB register access
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

module iar_alu_rotate
(
   input  wire logic                clk_sys,
   input  wire logic                reset,
   input  wire iar_pkg::iar_apb_req_t apb_req,
   output iar_pkg::iar_apb_rsp_t    apb_rsp,
   output logic [7:0]               acc_out,
   output iar_pkg::iar_flags_t      flags_out,
   output logic                     busy_out,
   output logic                     done_out
);
   import iar_pkg::*;

   // Flag evaluation from an 8-bit result and a carry
   function automatic iar_flags_t calc_flags
   (
      input logic [7:0] res,
      input logic       cy
   );
      iar_flags_t f;
      f.carry  = cy;
      f.zero   = (res == 8'h00);
      f.sign   = res[7];
      f.parity = ~^res;
      return f;
   endfunction

   // Borrowing 8-bit subtraction
   function automatic logic [8:0] sub_borrow
   (
      input logic [7:0] lhs,
      input logic [7:0] rhs,
      input logic       bin
   );
      return {1'b0, lhs} - {1'b0, rhs} - {8'h00, bin};
   endfunction

   // Registers
   logic [7:0]  acc_ff;
   logic [7:0]  opcode_ff;
   logic [7:0]  operand_ff;
   iar_flags_t  flags_ff;
   iar_seq_t    seq_ff;
   logic [2:0]  cnt_ff;
   logic        done_ff;
   logic        illeg_ff;
   logic        pulse_ff;
   logic        busy_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;

   // Next values
   logic [7:0]  nxt_acc;
   logic [7:0]  nxt_opcode;
   logic [7:0]  nxt_operand;
   iar_flags_t  nxt_flags;
   iar_seq_t    nxt_seq;
   logic [2:0]  nxt_cnt;
   logic        nxt_done;
   logic        nxt_illeg;
   logic [31:0] nxt_prdata;
   logic        nxt_pready;
   logic        nxt_pslverr;

   // Bus decode
   wire acc_phase = apb_req.psel & apb_req.penable;
   wire take      = acc_phase & pready_ff;
   wire wr_take   = take & apb_req.pwrite;
   wire hit_ctrl  = (apb_req.paddr == ADDR_CTRL);
   wire hit_opc   = (apb_req.paddr == ADDR_OPCODE);
   wire hit_opr   = (apb_req.paddr == ADDR_OPERAND);
   wire hit_acc   = (apb_req.paddr == ADDR_ACC);
   wire hit_flg   = (apb_req.paddr == ADDR_FLAGS);
   wire hit_seq   = (apb_req.paddr == ADDR_SEQ);
   wire mapped    = hit_ctrl | hit_opc | hit_opr | hit_acc | hit_flg | hit_seq;
   wire busy      = (seq_ff != SEQ_IDLE);
   wire wr_ctrl   = wr_take & hit_ctrl;

   // Opcode decode
   wire is_sbi = (opcode_ff == OP_SUBTRACT_IMMEDIATE_WITH_BORROW);
   wire is_and = (opcode_ff == OP_AND_IMMEDIATE);
   wire is_xor = (opcode_ff == OP_XOR_IMMEDIATE);
   wire is_or  = (opcode_ff == OP_OR_IMMEDIATE);
   wire is_cmp = (opcode_ff == OP_COMPARE_IMMEDIATE);
   wire is_rlc = (opcode_ff == OP_ROTATE_LEFT_CIRCULAR);
   wire is_rrc = (opcode_ff == OP_ROTATE_RIGHT_CIRCULAR);
   wire is_ral = (opcode_ff == OP_ROTATE_LEFT_THROUGH_CARRY);
   wire is_rar = (opcode_ff == OP_ROTATE_RIGHT_THROUGH_CARRY);
   wire is_imm = is_sbi | is_and | is_xor | is_or | is_cmp;
   wire is_rot = is_rlc | is_rrc | is_ral | is_rar;

   // Start request and illegal opcode
   wire start_req = wr_ctrl & apb_req.pwdata[CTRL_START_BIT] & ~busy;
   wire start     = start_req & (is_imm | is_rot);
   wire illeg_set = start_req & ~(is_imm | is_rot);

   // Sequencer milestones
   // Fetch then read, eight states; rotates end after the five fetch states
   wire fetch_last = (seq_ff == SEQ_FETCH) & (cnt_ff == FETCH_STATES - 3'd1);
   wire read_last  = (seq_ff == SEQ_READ) & (cnt_ff == READ_STATES - 3'd1);
   wire exec_now   = (fetch_last & is_rot) | read_last;

   wire [8:0] diff_sbi = sub_borrow(acc_ff, operand_ff, flags_ff.carry);
   wire [8:0] diff_cmp = sub_borrow(acc_ff, operand_ff, 1'b0);

   wire [7:0] res_and = acc_ff & operand_ff;
   wire [7:0] res_xor = acc_ff ^ operand_ff;
   wire [7:0] res_or  = acc_ff | operand_ff;

   wire [7:0] res_rlc = {acc_ff[6:0], acc_ff[7]};
   wire [7:0] res_rrc = {acc_ff[0], acc_ff[7:1]};
   wire [7:0] res_ral = {acc_ff[6:0], flags_ff.carry};
   wire [7:0] res_rar = {flags_ff.carry, acc_ff[7:1]};
   wire       rot_cy  = (is_rlc | is_ral) ? acc_ff[7] : acc_ff[0];
   wire [7:0] res_rot = is_rlc ? res_rlc :
                        is_rrc ? res_rrc :
                        is_ral ? res_ral : res_rar;

   wire [7:0] exec_acc = is_sbi ? diff_sbi[7:0] :
                         is_and ? res_and :
                         is_xor ? res_xor :
                         is_or  ? res_or :
                         is_cmp ? acc_ff : res_rot;

   wire [7:0] flag_res = is_sbi ? diff_sbi[7:0] :
                         is_cmp ? diff_cmp[7:0] : exec_acc;
   wire       flag_cy  = is_sbi ? diff_sbi[8] :
                         is_cmp ? diff_cmp[8] : 1'b0;
   wire iar_flags_t alu_flags = calc_flags(flag_res, flag_cy);
   wire iar_flags_t rot_flags = '{parity: flags_ff.parity, sign: flags_ff.sign,
                                  zero: flags_ff.zero, carry: rot_cy};
   wire iar_flags_t exec_flags = is_rot ? rot_flags : alu_flags;

   // Register updates; sequencer owns state while busy
   // Four condition flags held
   assign nxt_acc     = exec_now ? exec_acc :
                        (wr_take & hit_acc & ~busy) ? apb_req.pwdata[7:0] : acc_ff;
   assign nxt_flags   = exec_now ? exec_flags :
                        (wr_take & hit_flg & ~busy) ? iar_flags_t'(apb_req.pwdata[3:0]) :
                        flags_ff;
   assign nxt_opcode  = (wr_take & hit_opc & ~busy) ? apb_req.pwdata[7:0] : opcode_ff;
   // Operand byte never written by execution
   assign nxt_operand = (wr_take & hit_opr & ~busy) ? apb_req.pwdata[7:0] : operand_ff;

   // Sticky status, set wins over clear
   assign nxt_done  = exec_now | (done_ff & ~(wr_ctrl & apb_req.pwdata[CTRL_CLR_DONE_BIT]));
   assign nxt_illeg = illeg_set | (illeg_ff & ~(wr_ctrl & apb_req.pwdata[CTRL_CLR_ILLEG_BIT]));

   // State time counter
   assign nxt_cnt = (start | fetch_last | read_last) ? 3'd0 :
                    busy ? cnt_ff + 3'd1 : cnt_ff;

   // Machine cycle sequencer
   always_comb
   begin
      nxt_seq = seq_ff;
      unique case (seq_ff)
         SEQ_IDLE:
         begin
            if (start)
               nxt_seq = SEQ_FETCH;
         end
         SEQ_FETCH:
         begin
            if (fetch_last)
               nxt_seq = is_rot ? SEQ_IDLE : SEQ_READ;
         end
         SEQ_READ:
         begin
            if (read_last)
               nxt_seq = SEQ_IDLE;
         end
         default:
         begin
            nxt_seq = SEQ_IDLE;
         end
      endcase
   end

   // Read data mux
   wire [31:0] rd_ctrl = {29'h0000000, illeg_ff, done_ff, busy};
   wire [31:0] rd_data = hit_ctrl ? rd_ctrl :
                         hit_opc  ? {24'h000000, opcode_ff} :
                         hit_opr  ? {24'h000000, operand_ff} :
                         hit_acc  ? {24'h000000, acc_ff} :
                         hit_flg  ? {28'h0000000, flags_ff} :
                         hit_seq  ? {27'h0000000, seq_ff, cnt_ff} : 32'h00000000;

   // One wait state on every access
   assign nxt_pready  = acc_phase & ~pready_ff;
   assign nxt_prdata  = (acc_phase & ~pready_ff & ~apb_req.pwrite) ? rd_data : 32'h00000000;
   assign nxt_pslverr = acc_phase & ~pready_ff & ~mapped;

   // Datapath state
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         acc_ff     <= ACC_RESET;
         flags_ff   <= iar_flags_t'(FLAGS_RESET);
         opcode_ff  <= OPCODE_RESET;
         operand_ff <= OPERAND_RESET;
      end
      else
      begin
         acc_ff     <= nxt_acc;
         flags_ff   <= nxt_flags;
         opcode_ff  <= nxt_opcode;
         operand_ff <= nxt_operand;
      end
   end

   // Sequencer and status
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         seq_ff   <= SEQ_IDLE;
         cnt_ff   <= 3'd0;
         done_ff  <= 1'b0;
         illeg_ff <= 1'b0;
         pulse_ff <= 1'b0;
         busy_ff  <= 1'b0;
      end
      else
      begin
         seq_ff   <= nxt_seq;
         cnt_ff   <= nxt_cnt;
         done_ff  <= nxt_done;
         illeg_ff <= nxt_illeg;
         pulse_ff <= exec_now;
         busy_ff  <= (nxt_seq != SEQ_IDLE);
      end
   end

   // Bus response
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         prdata_ff  <= 32'h00000000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Outputs
   assign apb_rsp.prdata  = prdata_ff;
   assign apb_rsp.pready  = pready_ff;
   assign apb_rsp.pslverr = pslverr_ff;
   assign acc_out         = acc_ff;
   assign flags_out       = flags_ff;
   assign busy_out        = busy_ff;
   assign done_out        = pulse_ff;

endmodule

// ---- rtl/iar_pkg.sv ----
// Constants, types and register map of the immediate ALU and rotate block
package iar_pkg;

   // Opcodes handled by the block
   localparam logic [7:0] OP_SUBTRACT_IMMEDIATE_WITH_BORROW = 8'h1c;
   localparam logic [7:0] OP_AND_IMMEDIATE                  = 8'h24;
   localparam logic [7:0] OP_XOR_IMMEDIATE                  = 8'h2c;
   localparam logic [7:0] OP_OR_IMMEDIATE                   = 8'h34;
   localparam logic [7:0] OP_COMPARE_IMMEDIATE              = 8'h3c;
   localparam logic [7:0] OP_ROTATE_LEFT_CIRCULAR           = 8'h02;
   localparam logic [7:0] OP_ROTATE_RIGHT_CIRCULAR          = 8'h0a;
   localparam logic [7:0] OP_ROTATE_LEFT_THROUGH_CARRY      = 8'h12;
   localparam logic [7:0] OP_ROTATE_RIGHT_THROUGH_CARRY     = 8'h1a;

   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_OPCODE  = 12'h004;
   localparam logic [11:0] ADDR_OPERAND = 12'h008;
   localparam logic [11:0] ADDR_ACC     = 12'h00c;
   localparam logic [11:0] ADDR_FLAGS   = 12'h010;
   localparam logic [11:0] ADDR_SEQ     = 12'h014;

   // Control and status bit positions
   localparam int CTRL_START_BIT     = 0;
   localparam int CTRL_CLR_DONE_BIT  = 1;
   localparam int CTRL_CLR_ILLEG_BIT = 2;
   localparam int STAT_BUSY_BIT      = 0;
   localparam int STAT_DONE_BIT      = 1;
   localparam int STAT_ILLEG_BIT     = 2;

   // Reset values
   localparam logic [7:0] ACC_RESET     = 8'h00;
   localparam logic [7:0] OPCODE_RESET  = 8'h00;
   localparam logic [7:0] OPERAND_RESET = 8'h00;
   localparam logic [3:0] FLAGS_RESET   = 4'h0;

   // State times per machine cycle
   localparam logic [2:0] FETCH_STATES = 3'd5;
   localparam logic [2:0] READ_STATES  = 3'd3;

   typedef enum logic [1:0]
   {
      SEQ_IDLE  = 2'b00,
      SEQ_FETCH = 2'b01,
      SEQ_READ  = 2'b10
   } iar_seq_t;

   typedef struct packed
   {
      logic parity;
      logic sign;
      logic zero;
      logic carry;
   } iar_flags_t;

   typedef struct packed
   {
      logic [11:0] paddr;
      logic        pwrite;
      logic [31:0] pwdata;
      logic        psel;
      logic        penable;
   } iar_apb_req_t;

   typedef struct packed
   {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } iar_apb_rsp_t;

endpackage

// ---- tb/iar_alu_rotate_asserts.sv ----
// Port assertions for the immediate ALU and rotate unit
`timescale 1ns/1ps
module iar_alu_rotate_asserts
(
   input wire logic                  clk_sys,
   input wire logic                  reset,
   input wire iar_pkg::iar_apb_req_t apb_req,
   input wire iar_pkg::iar_apb_rsp_t apb_rsp,
   input wire logic [7:0]            acc_out,
   input wire iar_pkg::iar_flags_t   flags_out,
   input wire logic                  busy_out,
   input wire logic                  done_out
);
   import iar_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   wire wr_done = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;
   sequence rot_s;
      busy_out [*5] ##1 !busy_out;
   endsequence
   sequence imm_s;
      busy_out [*8] ##1 !busy_out;
   endsequence
   busy_len_a: assert property ($rose(busy_out) |-> rot_s or imm_s)
      else $error("busy length wrong");
   done_pulse_a: assert property ($fell(busy_out) |-> ##[0:1] done_out ##1 !done_out)
      else $error("done pulse wrong");
   acc_hold_a: assert property ($changed(acc_out) |-> $fell(busy_out) || $past(wr_done))
      else $error("acc changed without cause");
   flags_hold_a: assert property ($changed(flags_out) |-> $fell(busy_out) || $past(wr_done))
      else $error("flags changed without cause");
   ready_lat_a: assert property ($rose(apb_req.penable) |-> !apb_rsp.pready ##1 apb_rsp.pready)
      else $error("ready latency wrong");
   ready_one_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("ready too long");
   ready_access_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
      else $error("ready outside access");
   slverr_rdy_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
      else $error("error without ready");
   rdata_idle_a: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
      else $error("read data not zero");
endmodule
bind iar_alu_rotate iar_alu_rotate_asserts i_chk (.clk_sys, .reset, .apb_req, .apb_rsp,
   .acc_out, .flags_out, .busy_out, .done_out);

// ---- tb/iar_host_model.sv ----
// Host model issuing APB bus transfers with a stuck flag on timeout
`timescale 1ns/1ps
module iar_host_model
(
   input wire logic                  clk_sys,
   output iar_pkg::iar_apb_req_t     apb_req,
   input wire iar_pkg::iar_apb_rsp_t apb_rsp,
   output logic                      stuck
);
   initial
   begin
      apb_req = '0;
      stuck = 1'b0;
   end
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      apb_req.paddr <= a;
      apb_req.pwrite <= w;
      apb_req.pwdata <= d;
      apb_req.psel <= 1'b1;
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (apb_rsp.pready !== 1'b1 && n < 20);
      if (n == 20)
         stuck <= 1'b1;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      apb_req.pwdata <= ~d;
   endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the immediate ALU and rotate unit
`timescale 1ns/1ps
module tb;
   import iar_pkg::*;
   localparam logic [71:0] OPS = {OP_SUBTRACT_IMMEDIATE_WITH_BORROW, OP_AND_IMMEDIATE,
      OP_XOR_IMMEDIATE, OP_OR_IMMEDIATE, OP_COMPARE_IMMEDIATE, OP_ROTATE_LEFT_CIRCULAR,
      OP_ROTATE_RIGHT_CIRCULAR, OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY};
   logic         clk_sys;
   logic         reset;
   iar_apb_req_t apb_req;
   iar_apb_rsp_t apb_rsp;
   logic [7:0]   acc_out;
   iar_flags_t   flags_out;
   logic         busy_out;
   logic         done_out;
   logic         stuck;
   int           errors;
   int           tests_run;
   logic [31:0]  seed;
   logic [32:0]  expq [$];
   iar_alu_rotate i_iar_alu_rotate (.clk_sys(clk_sys), .reset(reset), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .acc_out(acc_out), .flags_out(flags_out), .busy_out(busy_out),
      .done_out(done_out));
   iar_host_model u_host (.clk_sys(clk_sys), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .stuck(stuck));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [11:0] ref_op(logic [7:0] op, logic [7:0] a, logic [7:0] b,
      iar_flags_t f);
      logic [8:0] d;
      logic [7:0] r;
      iar_flags_t n;
      n = f;
      r = a;
      d = {1'b0, a} - {1'b0, b};
      case (op)
         OP_SUBTRACT_IMMEDIATE_WITH_BORROW: d = d - f.carry;
         OP_AND_IMMEDIATE: d = {1'b0, a & b};
         OP_XOR_IMMEDIATE: d = {1'b0, a ^ b};
         OP_OR_IMMEDIATE: d = {1'b0, a | b};
         OP_ROTATE_LEFT_CIRCULAR: {n.carry, r} = {a[7], a[6:0], a[7]};
         OP_ROTATE_RIGHT_CIRCULAR: {r, n.carry} = {a[0], a[7:1], a[0]};
         OP_ROTATE_LEFT_THROUGH_CARRY: {n.carry, r} = {a, f.carry};
         OP_ROTATE_RIGHT_THROUGH_CARRY: {r, n.carry} = {f.carry, a};
         default: r = a;
      endcase
      if (op[2])
         n = {~^d[7:0], d[7], ~|d[7:0], d[8]};
      if (op[2] && op != OP_COMPARE_IMMEDIATE)
         r = d[7:0];
      return {r, n};
   endfunction
   task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] exp);
      expq.push_back(exp);
      u_host.xfer(a, 1'b0, 32'h0);
   endtask
   task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
      input iar_flags_t f, input logic poke);
      logic [11:0] r;
      int n;
      r = ref_op(op, a, b, f);
      u_host.xfer(ADDR_ACC, 1'b1, {24'h0, a});
      u_host.xfer(ADDR_OPERAND, 1'b1, {24'h0, b});
      u_host.xfer(ADDR_FLAGS, 1'b1, {28'h0, f});
      u_host.xfer(ADDR_OPCODE, 1'b1, {24'h0, op});
      u_host.xfer(ADDR_CTRL, 1'b1, 32'h1);
      if (poke)
         u_host.xfer(ADDR_FLAGS, 1'b1, 32'hf);
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (busy_out !== 1'b0 && n < 20);
      if (n == 20)
      begin
         errors++;
         summarize();
      end
      if (!poke)
         check(n - 1, op[2] ? 8 : 5, "states");
      check(done_out, 1'b1, "done");
      check(acc_out, r[11:4], "acc port");
      check(flags_out, r[3:0], "flags port");
      rd(ADDR_ACC, {25'h0, r[11:4]});
      rd(ADDR_FLAGS, {29'h0, r[3:0]});
      rd(ADDR_OPERAND, {25'h0, b});
      $display("op %h done", op);
   endtask
   always @(posedge clk_sys)
   begin
      if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 && !apb_req.pwrite)
         check({apb_rsp.pslverr, apb_rsp.prdata}, expq.pop_front(), "read");
   end
   always @(posedge stuck)
   begin
      errors++;
      summarize();
   end
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial
   begin
      logic [31:0] x;
      seed = 32'd17374;
      errors = 0;
      tests_run = 0;
      reset = 1'b1;
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      rd(ADDR_ACC, 33'h0);
      rd(ADDR_FLAGS, 33'h0);
      rd(12'h018, 33'h1_0000_0000);
      run(OP_COMPARE_IMMEDIATE, 8'h40, 8'h40, 4'h0, 1'b0);
      run(OP_COMPARE_IMMEDIATE, 8'h10, 8'h11, 4'h0, 1'b0);
      run(OP_SUBTRACT_IMMEDIATE_WITH_BORROW, 8'h00, 8'h00, 4'h1, 1'b0);
      for (int i = 0; i < 36; i++)
      begin
         x = rnd();
         run(OPS[71 - 8 * (i % 9) -: 8], x[7:0], x[15:8], x[19:16], 1'b0);
      end
      run(OP_ROTATE_RIGHT_THROUGH_CARRY, 8'h0b, 8'h00, 4'h1, 1'b1);
      u_host.xfer(ADDR_OPCODE, 1'b1, 32'h0);
      u_host.xfer(ADDR_CTRL, 1'b1, 32'h1);
      rd(ADDR_CTRL, 33'h6);
      u_host.xfer(ADDR_CTRL, 1'b1, 32'h6);
      rd(ADDR_CTRL, 33'h0);
      rd(ADDR_SEQ, 33'h0);
      @(posedge clk_sys);
      summarize();
   end
endmodule
